// [core/reg_access_pkg.sv]
// Shared types, access codes, layout and reset values of the register field bank.
package reg_access_pkg;

  // ****************************************************************
  // Sizes and layout
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 9;

  // Word index of each demonstration register; each word holds one access type.
  localparam logic [ADDR_W-1:0] IDX_RW = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_RO = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_WO = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_C1 = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_C0 = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_COR = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_SET = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_TRIG = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_TGL = 4'h8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_RW = 8'hA5;
  localparam logic [DATA_W-1:0] RST_RO = 8'h00;
  localparam logic [DATA_W-1:0] RST_WO = 8'h5A;
  localparam logic [DATA_W-1:0] RST_C1 = 8'h00;
  localparam logic [DATA_W-1:0] RST_C0 = 8'h00;
  localparam logic [DATA_W-1:0] RST_COR = 8'h00;
  localparam logic [DATA_W-1:0] RST_SET = 8'h00;
  localparam logic [DATA_W-1:0] RST_TRIG = 8'h00;
  localparam logic [DATA_W-1:0] RST_TGL = 8'h0F;
  localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

  // ****************************************************************
  // Access types
  // ****************************************************************
  typedef enum logic [3:0] {
    ACC_RW = 4'b0000,
    ACC_RO = 4'b0001,
    ACC_WO = 4'b0010,
    ACC_CLEAR_BY_WRITE_ONE = 4'b0011,
    ACC_CLEAR_BY_WRITE_ZERO = 4'b0100,
    ACC_CLEAR_ON_READ = 4'b0101,
    ACC_SET_ONLY = 4'b0110,
    ACC_WRITE_TRIGGER_EVENT = 4'b0111,
    ACC_TOGGLE = 4'b1000
  } access_t;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef logic [NUM_REGS-1:0][DATA_W-1:0] word_array_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [DATA_W-1:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    logic value;
    logic trig;
  } cell_state_t;

  typedef struct packed {
    reg_rsp_t rsp;
  } top_state_t;

  // ****************************************************************
  // Map from word index to access type and reset value
  // ****************************************************************
  function automatic access_t access_of(input logic [ADDR_W-1:0] idx);
    access_t a;
    case (idx)
      IDX_RW: a = ACC_RW;
      IDX_RO: a = ACC_RO;
      IDX_WO: a = ACC_WO;
      IDX_C1: a = ACC_CLEAR_BY_WRITE_ONE;
      IDX_C0: a = ACC_CLEAR_BY_WRITE_ZERO;
      IDX_COR: a = ACC_CLEAR_ON_READ;
      IDX_SET: a = ACC_SET_ONLY;
      IDX_TRIG: a = ACC_WRITE_TRIGGER_EVENT;
      IDX_TGL: a = ACC_TOGGLE;
      default: a = ACC_RW;
    endcase
    return a;
  endfunction

  function automatic logic [DATA_W-1:0] reset_of(input logic [ADDR_W-1:0] idx);
    logic [DATA_W-1:0] r;
    case (idx)
      IDX_RW: r = RST_RW;
      IDX_RO: r = RST_RO;
      IDX_WO: r = RST_WO;
      IDX_C1: r = RST_C1;
      IDX_C0: r = RST_C0;
      IDX_COR: r = RST_COR;
      IDX_SET: r = RST_SET;
      IDX_TRIG: r = RST_TRIG;
      IDX_TGL: r = RST_TGL;
      default: r = RDATA_NONE;
    endcase
    return r;
  endfunction

endpackage

// [core/field_cell.sv]
// One register bit with a fixed access behaviour.
`timescale 1ns/100ps
module field_cell
  import reg_access_pkg::*;
#(
  parameter access_t ACCESS = ACC_RW,
  parameter logic RESET_VAL = 1'h0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic wr,
  input wire logic rd,
  input wire logic wbit,
  input wire logic hw_val,
  input wire logic hw_set,
  output logic value,
  output logic rd_bit,
  output logic trig
);

  cell_state_t s_q;
  cell_state_t s_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // A hardware set is applied last so that an event landing in the clearing cycle survives.
  always_comb begin
    s_d = s_q;
    s_d.trig = 1'h0;
    case (ACCESS)
      // R1: software sets and clears
      // R2: holds last written value
      ACC_RW: begin
        if (wr) begin
          s_d.value = wbit;
        end
      end
      // R3: hardware value only
      ACC_RO: begin
        s_d.value = hw_val;
      end
      // R4: stores writes, hidden
      ACC_WO: begin
        if (wr) begin
          s_d.value = wbit;
        end
      end
      // R5: one clears flag
      ACC_CLEAR_BY_WRITE_ONE: begin
        if (wr && wbit) begin
          s_d.value = 1'h0;
        end
        if (hw_set) begin
          s_d.value = 1'h1;
        end
      end
      // R6: zero clears flag
      ACC_CLEAR_BY_WRITE_ZERO: begin
        if (wr && !wbit) begin
          s_d.value = 1'h0;
        end
        if (hw_set) begin
          s_d.value = 1'h1;
        end
      end
      // R7: read clears flag
      ACC_CLEAR_ON_READ: begin
        if (rd) begin
          s_d.value = 1'h0;
        end
        if (hw_set) begin
          s_d.value = 1'h1;
        end
      end
      // R8: one sets bit
      ACC_SET_ONLY: begin
        if (wr && wbit) begin
          s_d.value = 1'h1;
        end
      end
      // R9: write fires event
      ACC_WRITE_TRIGGER_EVENT: begin
        s_d.value = hw_val;
        if (wr) begin
          s_d.trig = 1'h1;
        end
      end
      // R10: one inverts bit
      ACC_TOGGLE: begin
        if (wr && wbit) begin
          s_d.value = ~s_q.value;
        end
      end
      default: begin
        s_d = s_q;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // R11: parameter reset value
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{value: RESET_VAL, trig: 1'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  // R4: reads give reset value
  assign rd_bit = (ACCESS == ACC_WO) ? RESET_VAL : s_q.value;
  assign trig = s_q.trig;

  // ****************************************************************
  // Checks
  // ****************************************************************
  if (ACCESS == ACC_RW) begin : g_chk_rw
    property p_rw_write;
      @(posedge ref_clk) disable iff (!nrst) wr |=> (rd_bit == $past(wbit));
    endproperty
    a_rw_write: assert property (p_rw_write) else $error("rw field lost a write"); // R1
    property p_rw_hold;
      @(posedge ref_clk) disable iff (!nrst) !wr |=> $stable(rd_bit);
    endproperty
    a_rw_hold: assert property (p_rw_hold) else $error("rw field changed unwritten"); // R2
  end
  if (ACCESS == ACC_RO) begin : g_chk_ro
    property p_ro_follow;
      @(posedge ref_clk) disable iff (!nrst) nrst |=> (rd_bit == $past(hw_val));
    endproperty
    a_ro_follow: assert property (p_ro_follow) else $error("ro field not hw value"); // R3
  end
  if (ACCESS == ACC_WO) begin : g_chk_wo
    property p_wo_read;
      @(posedge ref_clk) disable iff (!nrst) wr |=> (rd_bit == RESET_VAL) && (value == $past(wbit));
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("wo field read not reset value"); // R4
  end
  if (ACCESS == ACC_CLEAR_BY_WRITE_ONE) begin : g_chk_c1
    property p_c1_clear;
      @(posedge ref_clk) disable iff (!nrst)
        (wr && !hw_set) |=> (value == ($past(wbit) ? 1'h0 : $past(value)));
    endproperty
    a_c1_clear: assert property (p_c1_clear) else $error("clear by one misbehaved"); // R5
  end
  if (ACCESS == ACC_CLEAR_BY_WRITE_ZERO) begin : g_chk_c0
    property p_c0_clear;
      @(posedge ref_clk) disable iff (!nrst)
        (wr && !hw_set) |=> (value == ($past(wbit) ? $past(value) : 1'h0));
    endproperty
    a_c0_clear: assert property (p_c0_clear) else $error("clear by zero misbehaved"); // R6
  end
  if (ACCESS == ACC_CLEAR_ON_READ) begin : g_chk_cor
    property p_cor_clear;
      @(posedge ref_clk) disable iff (!nrst)
        (rd && !hw_set) |=> !value ##1 (!value || $past(hw_set));
    endproperty
    a_cor_clear: assert property (p_cor_clear) else $error("clear on read misbehaved"); // R7
    property p_cor_wr;
      @(posedge ref_clk) disable iff (!nrst) (wr && !rd && !hw_set) |=> $stable(value);
    endproperty
    a_cor_wr: assert property (p_cor_wr) else $error("write changed clear on read"); // R7
  end
  if (ACCESS == ACC_SET_ONLY) begin : g_chk_set
    property p_set_one;
      @(posedge ref_clk) disable iff (!nrst)
        wr |=> (value == ($past(wbit) ? 1'h1 : $past(value)));
    endproperty
    a_set_one: assert property (p_set_one) else $error("set only misbehaved"); // R8
  end
  if (ACCESS == ACC_WRITE_TRIGGER_EVENT) begin : g_chk_trig
    property p_trig_fire;
      @(posedge ref_clk) disable iff (!nrst) wr |=> trig && (value == $past(hw_val));
    endproperty
    a_trig_fire: assert property (p_trig_fire) else $error("write did not fire event"); // R9
    property p_trig_quiet;
      @(posedge ref_clk) disable iff (!nrst) !wr |=> !trig;
    endproperty
    a_trig_quiet: assert property (p_trig_quiet) else $error("event without write"); // R9
  end
  if (ACCESS == ACC_TOGGLE) begin : g_chk_tgl
    property p_tgl_flip;
      @(posedge ref_clk) disable iff (!nrst)
        wr |=> (value == ($past(wbit) ? !$past(value) : $past(value)));
    endproperty
    a_tgl_flip: assert property (p_tgl_flip) else $error("toggle misbehaved"); // R10
  end

endmodule

// [core/reg_word.sv]
// One register word: address decode and one field cell per bit.
`timescale 1ns/100ps
module reg_word
  import reg_access_pkg::*;
#(
  parameter logic [ADDR_W-1:0] INDEX = 4'h0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire reg_req_t req,
  input wire logic [DATA_W-1:0] hw_val,
  input wire logic [DATA_W-1:0] hw_set,
  output logic [DATA_W-1:0] value,
  output logic [DATA_W-1:0] rd_word,
  output logic [DATA_W-1:0] trig
);

  localparam access_t ACCESS = access_of(INDEX);
  localparam logic [DATA_W-1:0] RESET_WORD = reset_of(INDEX);

  logic hit;

  assign hit = (req.addr == INDEX);

  // ****************************************************************
  // Field cells
  // ****************************************************************
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    field_cell #(
      .ACCESS(ACCESS),
      .RESET_VAL(RESET_WORD[b])
    ) u_cell (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .wr(req.wr_en && hit),
      .rd(req.rd_en && hit),
      .wbit(req.wdata[b]),
      .hw_val(hw_val[b]),
      .hw_set(hw_set[b]),
      .value(value[b]),
      .rd_bit(rd_word[b]),
      .trig(trig[b])
    );
  end

endmodule

// [core/register_field_access_library.sv]
// Register bank demonstrating every field access type over a generic read/write port.
//
// Operation
// R1: Control fields follow software writes directly.
// R2: Read/write returns last write or reset.
// R3: Read-only shows hardware value, ignores writes.
// R4: Write-only reads always return reset value.
// R5: Writing one clears; zero ignored.
// R6: Writing zero clears; one ignored.
// R7: Read returns value then clears; writes ignored.
// R8: Writing one sets; zero ignored.
// R9: Any write fires event, value unchanged.
// R10: Writing one inverts; zero ignored.
// R11: Fixed access type, parameter reset value.
`timescale 1ns/100ps
module register_field_access_library
  import reg_access_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire reg_req_t req,
  input wire word_array_t hw_val,
  input wire word_array_t hw_set,
  output word_array_t field_q,
  output word_array_t trig_q,
  output reg_rsp_t rsp_q
);

  word_array_t rd_words;
  top_state_t s_q;
  top_state_t s_d;
  logic mapped;

  // ****************************************************************
  // Register words
  // ****************************************************************
  // Each word takes its access type and reset value from its index at elaboration.
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
    reg_word #(
      .INDEX(ADDR_W'(i))
    ) u_word (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .req(req),
      .hw_val(hw_val[i]),
      .hw_set(hw_set[i]),
      .value(field_q[i]),
      .rd_word(rd_words[i]),
      .trig(trig_q[i])
    );
  end

  // ****************************************************************
  // Read response
  // ****************************************************************
  assign mapped = (req.addr < ADDR_W'(NUM_REGS));

  // The read samples the value before any clear or write of the same edge takes effect.
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = req.rd_en;
    s_d.rsp.err = req.rd_en && !mapped;
    s_d.rsp.rdata = RDATA_NONE;
    if (req.rd_en && mapped) begin
      s_d.rsp.rdata = rd_words[req.addr];
    end
  end

  // R11: response cleared at reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{rsp: '{valid: 1'h0, err: 1'h0, rdata: RDATA_NONE}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_q = s_q.rsp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rd_answer;
    @(posedge ref_clk) disable iff (!nrst) req.rd_en |=> rsp_q.valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered"); // R2

  property p_rd_quiet;
    @(posedge ref_clk) disable iff (!nrst) !req.rd_en |=> !rsp_q.valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("answer without read"); // R2

  property p_unmapped;
    @(posedge ref_clk) disable iff (!nrst)
      (req.rd_en && !mapped) |=> rsp_q.err && (rsp_q.rdata == RDATA_NONE);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused"); // R3

  property p_wo_readback;
    @(posedge ref_clk) disable iff (!nrst)
      (req.rd_en && req.addr == IDX_WO) |=> (rsp_q.rdata == RST_WO);
  endproperty
  a_wo_readback: assert property (p_wo_readback) else $error("wo word read wrong"); // R4

  property p_rw_readback;
    @(posedge ref_clk) disable iff (!nrst)
      (req.wr_en && req.addr == IDX_RW) ##1 (req.rd_en && req.addr == IDX_RW && !req.wr_en)
        |=> (rsp_q.rdata == $past(req.wdata, 2));
  endproperty
  a_rw_readback: assert property (p_rw_readback) else $error("rw word readback wrong"); // R2

  property p_cor_word;
    @(posedge ref_clk) disable iff (!nrst)
      (req.rd_en && req.addr == IDX_COR) |=>
        (rsp_q.rdata == $past(field_q[IDX_COR])) && (field_q[IDX_COR] == $past(hw_set[IDX_COR]));
  endproperty
  a_cor_word: assert property (p_cor_word) else $error("clear on read word wrong"); // R7

endmodule

// [verif/register_field_access_library_tb.sv]
// Self-checking testbench for the register field access bank.
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module register_field_access_library_tb
  import reg_access_pkg::*;
;
  logic ref_clk;
  logic nrst;
  reg_req_t req;
  word_array_t hw_val;
  word_array_t hw_set;
  word_array_t field_q;
  word_array_t trig_q;
  word_array_t rst_tab;
  word_array_t saved;
  reg_rsp_t rsp_q;
  int err_total;
  int num_checks;

  register_field_access_library i_register_field_access_library (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .req(req),
    .hw_val(hw_val),
    .hw_set(hw_set),
    .field_q(field_q),
    .trig_q(trig_q),
    .rsp_q(rsp_q)
  );

  always #20 ref_clk = ~ref_clk;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // One request cycle; outputs are looked at once the answering edge has landed.
  task automatic xfer(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    req <= '{wr_en: w, rd_en: r, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
    #1;
  endtask

  task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [DATA_W-1:0] exp);
    xfer(1'b1, 1'b0, a, d);
    `CHK(field_q[a], exp)
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input logic err);
    xfer(1'b0, 1'b1, a, 8'h00);
    `CHK(rsp_q.valid, 1'b1)
    `CHK(rsp_q.err, err)
    `CHK(rsp_q.rdata, exp)
  endtask

  // Hardware raises flags for exactly one sampled edge.
  task automatic hset(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk);
    hw_set[a] <= v;
    @(posedge ref_clk);
    hw_set[a] <= '0;
    #1;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [DATA_W-1:0] exp;
    `CHK(field_q, rst_tab)
    `CHK(trig_q, '0)
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < NUM_REGS; i++) begin
      exp = (i == 1) ? 8'h3C : (i == 7) ? 8'h96 : rst_tab[i];
      rd_chk(i[ADDR_W-1:0], exp, 1'b0);
    end
  endtask

  task automatic t_rw();
    wr_chk(IDX_RW, 8'h3C, 8'h3C);
    rd_chk(IDX_RW, 8'h3C, 1'b0);
    xfer(1'b1, 1'b1, IDX_RW, 8'hC3);
    `CHK(rsp_q.rdata, 8'h3C)
    `CHK(field_q[IDX_RW], 8'hC3)
    rd_chk(IDX_RW, 8'hC3, 1'b0);
    // Back to back: the read in the cycle after a write must see the new data.
    @(posedge ref_clk);
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: IDX_RW, wdata: 8'h5A};
    @(posedge ref_clk);
    req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: IDX_RW, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1;
    `CHK(rsp_q.rdata, 8'h5A)
  endtask

  task automatic t_ro();
    wr_chk(IDX_RO, 8'hFF, 8'h3C);
    rd_chk(IDX_RO, 8'h3C, 1'b0);
    @(posedge ref_clk);
    hw_val[IDX_RO] <= 8'h81;
    repeat (2) @(posedge ref_clk);
    rd_chk(IDX_RO, 8'h81, 1'b0);
  endtask

  task automatic t_wo();
    wr_chk(IDX_WO, 8'h12, 8'h12);
    rd_chk(IDX_WO, 8'h5A, 1'b0);
  endtask

  task automatic t_clear();
    hset(IDX_C1, 8'hFF);
    wr_chk(IDX_C1, 8'h0F, 8'hF0);
    wr_chk(IDX_C1, 8'h00, 8'hF0);
    rd_chk(IDX_C1, 8'hF0, 1'b0);
    // A hardware set in the clearing cycle must survive the clear.
    @(posedge ref_clk);
    hw_set[IDX_C1] <= 8'h01;
    req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: IDX_C1, wdata: 8'hFF};
    @(posedge ref_clk);
    hw_set[IDX_C1] <= '0;
    req <= '0;
    #1;
    `CHK(field_q[IDX_C1], 8'h01)
    hset(IDX_C0, 8'hFF);
    wr_chk(IDX_C0, 8'h0F, 8'h0F);
    wr_chk(IDX_C0, 8'hFF, 8'h0F);
    rd_chk(IDX_C0, 8'h0F, 1'b0);
  endtask

  task automatic t_cor();
    hset(IDX_COR, 8'h55);
    wr_chk(IDX_COR, 8'hFF, 8'h55);
    wr_chk(IDX_COR, 8'h00, 8'h55);
    rd_chk(IDX_COR, 8'h55, 1'b0);
    `CHK(field_q[IDX_COR], 8'h00)
    rd_chk(IDX_COR, 8'h00, 1'b0);
  endtask

  task automatic t_set();
    wr_chk(IDX_SET, 8'h81, 8'h81);
    wr_chk(IDX_SET, 8'h00, 8'h81);
    wr_chk(IDX_SET, 8'h02, 8'h83);
    rd_chk(IDX_SET, 8'h83, 1'b0);
  endtask

  task automatic t_trig();
    logic [DATA_W-1:0] d;
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 8'h00 : 8'hFF;
      xfer(1'b1, 1'b0, IDX_TRIG, d);
      `CHK(trig_q[IDX_TRIG], 8'hFF)
      `CHK(trig_q[6:0], '0)
      `CHK(trig_q[8], 8'h00)
      `CHK(field_q[IDX_TRIG], 8'h96)
      @(posedge ref_clk);
      #1;
      `CHK(trig_q, '0)
    end
    rd_chk(IDX_TRIG, 8'h96, 1'b0);
  endtask

  task automatic t_tgl();
    wr_chk(IDX_TGL, 8'h3C, 8'h33);
    wr_chk(IDX_TGL, 8'h00, 8'h33);
    wr_chk(IDX_TGL, 8'hFF, 8'hCC);
    rd_chk(IDX_TGL, 8'hCC, 1'b0);
  endtask

  task automatic t_unmapped();
    saved = field_q;
    xfer(1'b1, 1'b0, 4'hC, 8'hFF);
    `CHK(field_q, saved)
    rd_chk(4'h9, 8'h00, 1'b1);
    rd_chk(4'hF, 8'h00, 1'b1);
  endtask

  // A reset in mid-run must bring back every parameterised reset value.
  task automatic t_rerst();
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1;
    `CHK(field_q, rst_tab)
    `CHK(rsp_q, '0)
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd_chk(IDX_TGL, 8'h0F, 1'b0);
  endtask

  // ****************************************************************
  // Verdict and sequence
  // ****************************************************************
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    hw_set = '0;
    hw_val = '0;
    hw_val[IDX_RO] = 8'h3C;
    hw_val[IDX_TRIG] = 8'h96;
    err_total = 0;
    num_checks = 0;
    rst_tab = {RST_TGL, RST_TRIG, RST_SET, RST_COR, RST_C0, RST_C1, RST_WO, RST_RO, RST_RW};
    repeat (10) @(posedge ref_clk);
    #1;
    t_reset();
    t_rw();
    t_ro();
    t_wo();
    t_clear();
    t_cor();
    t_set();
    t_trig();
    t_tgl();
    t_unmapped();
    t_rerst();
    results();
  end

  // The whole run needs about 120 cycles; the 5000-cycle limit leaves ample margin.
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    results();
  end
endmodule
